// ==== include/sfe_pkg.sv ====
// Shared constants and types for the serial flash erase and read sequencer.
// Contract
// - A dual read carries an eight-bit mode byte right after its address.
// - Mode pair 1,0 makes the next dual read start directly with address.
// - Any other mode pair returns the device to full opcode decoding.
// - A continuous-read reset clears the opcode-less state.
// - Opcode 81h clears one 256-byte page, three address bytes and no dummy byte.
// - Sector clear accepts any address; bit 12 upward picks the sector.
// - Sector and block clears end exactly on a byte boundary or die.
// - Opcodes 20, 52 and D8 are sector, 32K and 64K clears.
// - Opcodes 60 and C7 are whole-array clear without address.
// - A valid clear runs self-timed with busy high, then clears latch.
// - Status reads keep working during a clear cycle.
// - A protected sector is not cleared.
// - A protected 32K block stays intact but the latch is still reset.
// - A protected 64K block is not cleared.
// - Whole-array clear runs only when nothing is protected.
// - The 32K clear sets its whole block to ones from any address.
// - The 64K clear sets its whole block to ones from any address.
// - The upper data lines are ignored during clears.
// - Dual read moves address and mode two bits per clock, then data.
// - A dual read during a busy cycle is rejected harmlessly.
package sfe_pkg;

  localparam int ADDR_W = 18;
  localparam int RX_W = 24;

  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_PAGE = 8'h81;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_B32 = 8'h52;
  localparam logic [7:0] OP_B64 = 8'hD8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_DREAD = 8'hBB;
  localparam logic [7:0] OP_CRRST = 8'hFF;

  // Bit and clock counts within one select frame.
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] SER_BITS = 6'h20;
  localparam logic [5:0] DADDR_LAST = 6'h0B;
  localparam logic [5:0] DMODE_LAST = 6'h03;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [1:0] CONT_KEY = 2'h2;
  localparam int MODE_LO = 4;

  // Region sizes as address bit counts.
  localparam int PAGE_SH = 8;
  localparam int SECT_SH = 12;
  localparam int B32_SH = 15;
  localparam int B64_SH = 16;

  typedef enum logic [2:0] {
    K_PAGE, K_SECT, K_B32, K_B64, K_CHIP
  } sfe_kind_t;

  typedef struct packed {
    sfe_kind_t kind;
    logic [ADDR_W-1:0] addr;
  } sfe_erase_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DADDR, ST_DMODE, ST_DDATA, ST_STAT, ST_SKIP
  } sfe_state_t;

endpackage

// ==== design/sfe_sequencer.sv ====
// Serial flash command decode, clear sequencing and dual read front end.
`timescale 1ns/1ps
module sfe_sequencer
  import sfe_pkg::*;
#(
  parameter int PAGE_CYC = 2000,
  parameter int SECT_CYC = 5000,
  parameter int B32_CYC = 8000,
  parameter int B64_CYC = 10000,
  parameter int CHIP_CYC = 20000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic selN,
  input wire logic sclk,
  input wire logic [1:0] sioIn,
  output logic [1:0] sioOut,
  output logic [1:0] sioOe,
  input wire logic [4:0] protectBits,
  input wire logic [7:0] arrayData,
  output logic [ADDR_W-1:0] arrayRdAddr,
  output logic eraseValid,
  output sfe_erase_t eraseReq,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic contReadActive
);

  // Address mask covering one region of the given kind.
  function automatic logic [ADDR_W-1:0] kindMask(sfe_kind_t k);
    logic [ADDR_W-1:0] m;
    m = '1;
    unique case (k)
      K_PAGE: m = ADDR_W'((1 << PAGE_SH) - 1);
      K_SECT: m = ADDR_W'((1 << SECT_SH) - 1);
      K_B32: m = ADDR_W'((1 << B32_SH) - 1);
      K_B64: m = ADDR_W'((1 << B64_SH) - 1);
      K_CHIP: m = '1;
    endcase
    return m;
  endfunction

  // Protection covers the top of the array, doubling from one sector per step.
  // The region is protected if its highest address falls in that span.
  function automatic logic isProt(logic [ADDR_W-1:0] a, sfe_kind_t k,
                                  logic [4:0] bp);
    logic [ADDR_W-1:0] top;
    logic [ADDR_W-1:0] ones;
    int sb;
    top = a | kindMask(k);
    ones = '1;
    sb = SECT_SH + int'(bp) - 1;
    if (bp == 5'h0) begin
      return 1'b0;
    end
    if (k == K_CHIP || sb >= ADDR_W) begin
      return 1'b1;
    end
    return (top >> sb) == (ones >> sb);
  endfunction

  function automatic logic [23:0] cycFor(sfe_kind_t k);
    logic [23:0] c;
    c = 24'(CHIP_CYC);
    unique case (k)
      K_PAGE: c = 24'(PAGE_CYC);
      K_SECT: c = 24'(SECT_CYC);
      K_B32: c = 24'(B32_CYC);
      K_B64: c = 24'(B64_CYC);
      K_CHIP: c = 24'(CHIP_CYC);
    endcase
    return c;
  endfunction

  // Pin synchronisers; the second stage feeds the logic, and a third copy of select and clock finds edges.
  logic selS1, selS2, selPrev;
  logic sclkS1, sclkS2, sclkPrev;
  logic [1:0] sioS1, sioS2;

  always_ff @(posedge clk) begin
    if (srst) begin
      selS1 <= 1'b1;
      selS2 <= 1'b1;
      selPrev <= 1'b1;
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkPrev <= 1'b0;
      sioS1 <= 2'h0;
      sioS2 <= 2'h0;
    end else begin
      selS1 <= selN;
      selS2 <= selS1;
      selPrev <= selS2;
      sclkS1 <= sclk;
      sclkS2 <= sclkS1;
      sclkPrev <= sclkS2;
      sioS1 <= sioIn;
      sioS2 <= sioS1;
    end
  end

  logic riseEdge, fallEdge, selRise, selFall, selLow;
  assign riseEdge = sclkS2 & ~sclkPrev & ~selS2;
  assign fallEdge = ~sclkS2 & sclkPrev & ~selS2;
  assign selRise = selS2 & ~selPrev;
  assign selFall = ~selS2 & selPrev;
  assign selLow = ~selS2;

  sfe_state_t state_reg, state_next;
  logic [5:0] bitCnt_reg, bitCnt_next;
  logic [7:0] opc_reg, opc_next;
  logic [RX_W-1:0] rx_reg, rx_next;
  logic [7:0] mode_reg, mode_next;
  logic cont_reg, cont_next;
  logic latch_reg, latch_next;
  logic prog_reg, prog_next;
  logic [23:0] busy_reg, busy_next;
  sfe_kind_t busyKind_reg, busyKind_next;
  logic [ADDR_W-1:0] rdAddr_reg, rdAddr_next;
  logic [7:0] dataSh_reg, dataSh_next;
  logic [1:0] out_reg, out_next;
  logic [1:0] oe_reg, oe_next;
  logic ev_reg, ev_next;
  sfe_erase_t req_reg, req_next;

  // Next-state logic for the frame decoder and the self-timed cycle.
  // Upper data lines have no port at all, so clears cannot see them.
  always_comb begin
    logic [7:0] newOp;
    logic [7:0] newMode;
    logic [7:0] statusByte;
    logic startOk;
    sfe_kind_t k;
    logic prot;
    newOp = {opc_reg[6:0], sioS2[0]};
    newMode = {mode_reg[5:0], sioS2[1], sioS2[0]};
    statusByte = {6'h00, latch_reg, prog_reg};
    startOk = 1'b0;
    k = K_CHIP;
    prot = 1'b0;
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    opc_next = opc_reg;
    rx_next = rx_reg;
    mode_next = mode_reg;
    cont_next = cont_reg;
    latch_next = latch_reg;
    prog_next = prog_reg;
    busy_next = busy_reg;
    busyKind_next = busyKind_reg;
    rdAddr_next = rdAddr_reg;
    dataSh_next = dataSh_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    ev_next = 1'b0;
    req_next = req_reg;

    // Self-timed countdown; the end drops busy and the latch together.
    if (prog_reg) begin
      if (busy_reg == 24'h00_0000) begin
        prog_next = 1'b0;
        latch_next = 1'b0;
      end else begin
        busy_next = busy_reg - 24'h00_0001;
      end
    end

    if (selFall) begin
      bitCnt_next = 6'h00;
      oe_next = 2'h0;
      if (cont_reg) begin
        // Opcode-less read, but never while a cycle is running.
        state_next = prog_reg ? ST_SKIP : ST_DADDR;
      end else begin
        state_next = ST_OPC;
      end
    end else if (selRise) begin
      oe_next = 2'h0;
      state_next = ST_IDLE;
      unique case (opc_reg)
        OP_PAGE: k = K_PAGE;
        OP_SECT: k = K_SECT;
        OP_B32: k = K_B32;
        OP_B64: k = K_B64;
        default: k = K_CHIP;
      endcase
      // Clears need the latch, an idle device and an exact byte boundary.
      if (state_reg == ST_ADDR && bitCnt_reg == SER_BITS) begin
        startOk = latch_reg && !prog_reg;
      end
      if (state_reg == ST_OPC && bitCnt_reg == OPC_BITS) begin
        if (opc_reg == OP_CHIP_A || opc_reg == OP_CHIP_B) begin
          startOk = latch_reg && !prog_reg;
        end
        if (opc_reg == OP_WR_EN && !prog_reg) begin
          latch_next = 1'b1;
        end
        if (opc_reg == OP_CRRST) begin
          cont_next = 1'b0;
        end
      end
      // A frame that leaves an opcode-less read early is the reset sequence.
      if (state_reg == ST_DADDR) begin
        cont_next = 1'b0;
      end
      if (startOk) begin
        // Region base ignores the low address bits for any address inside.
        req_next.addr = rx_reg[ADDR_W-1:0] & ~kindMask(k);
        req_next.kind = k;
        prot = isProt(rx_reg[ADDR_W-1:0], k, protectBits);
        if (!prot) begin
          prog_next = 1'b1;
          busy_next = cycFor(k);
          busyKind_next = k;
          ev_next = 1'b1;
        end else if (k == K_B32) begin
          // Array untouched, yet the cycle still ends by dropping the latch.
          prog_next = 1'b1;
          busy_next = cycFor(k);
          busyKind_next = k;
        end
      end
    end else if (riseEdge) begin
      // Command phases saturate so an overlong frame never looks exact;
      // data phases wrap so long reads keep their byte rhythm.
      if (bitCnt_reg != CNT_MAX || state_reg == ST_STAT ||
          state_reg == ST_DDATA) begin
        bitCnt_next = bitCnt_reg + 6'h01;
      end
      unique case (state_reg)
        ST_OPC: begin
          if (bitCnt_reg < OPC_BITS) begin
            opc_next = newOp;
          end
          if (bitCnt_reg == OPC_BITS - 6'h01) begin
            bitCnt_next = OPC_BITS;
            if (newOp == OP_RDSR) begin
              state_next = ST_STAT;
              bitCnt_next = 6'h00;
            end else if (newOp == OP_DREAD) begin
              state_next = prog_reg ? ST_SKIP : ST_DADDR;
              bitCnt_next = 6'h00;
            end else if (newOp == OP_PAGE || newOp == OP_SECT ||
                         newOp == OP_B32 || newOp == OP_B64) begin
              state_next = ST_ADDR;
            end
          end
        end
        ST_ADDR: rx_next = {rx_reg[RX_W-2:0], sioS2[0]};
        ST_DADDR: begin
          rx_next = {rx_reg[RX_W-3:0], sioS2[1], sioS2[0]};
          if (bitCnt_reg == DADDR_LAST) begin
            state_next = ST_DMODE;
            bitCnt_next = 6'h00;
            rdAddr_next = rx_next[ADDR_W-1:0];
          end
        end
        ST_DMODE: begin
          mode_next = newMode;
          if (bitCnt_reg == DMODE_LAST) begin
            state_next = ST_DDATA;
            bitCnt_next = 6'h00;
            cont_next = (newMode[MODE_LO+1:MODE_LO] == CONT_KEY);
          end
        end
        default: ;
      endcase
    end else if (fallEdge) begin
      // Rising edges alone advance the count; a fall only shifts out what
      // that count points at, so one bus clock never counts twice.
      if (state_reg == ST_STAT) begin
        // Status is taken live each bit, so busy can drop mid-byte.
        out_next = {statusByte[~bitCnt_reg[2:0]], 1'b0};
        oe_next = 2'h2;
      end else if (state_reg == ST_DDATA) begin
        oe_next = 2'h3;
        if (bitCnt_reg[1:0] == 2'h0) begin
          out_next = arrayData[7:6];
          dataSh_next = {arrayData[5:0], 2'h0};
          rdAddr_next = rdAddr_reg + ADDR_W'(1);
        end else begin
          out_next = dataSh_reg[7:6];
          dataSh_next = {dataSh_reg[5:0], 2'h0};
        end
      end
    end
  end

  // Registers for the decoder and cycle state.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 6'h00;
      opc_reg <= 8'h00;
      rx_reg <= '0;
      mode_reg <= 8'h00;
      cont_reg <= 1'b0;
      latch_reg <= 1'b0;
      prog_reg <= 1'b0;
      busy_reg <= 24'h00_0000;
      busyKind_reg <= K_PAGE;
      rdAddr_reg <= '0;
      dataSh_reg <= 8'h00;
      out_reg <= 2'h0;
      oe_reg <= 2'h0;
      ev_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      opc_reg <= opc_next;
      rx_reg <= rx_next;
      mode_reg <= mode_next;
      cont_reg <= cont_next;
      latch_reg <= latch_next;
      prog_reg <= prog_next;
      busy_reg <= busy_next;
      busyKind_reg <= busyKind_next;
      rdAddr_reg <= rdAddr_next;
      dataSh_reg <= dataSh_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      ev_reg <= ev_next;
      req_reg <= req_next;
    end
  end

  // All outputs come straight from flip-flops.
  assign sioOut = out_reg;
  assign sioOe = oe_reg;
  assign arrayRdAddr = rdAddr_reg;
  assign eraseValid = ev_reg;
  assign eraseReq = req_reg;
  assign writeInProgress = prog_reg;
  assign writeEnableLatch = latch_reg;
  assign contReadActive = cont_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  busy_start_a: assert property (eraseValid |-> writeInProgress)
    else $error("Clear issued without busy.");
  busy_end_a: assert property ($fell(prog_reg) |-> !latch_reg)
    else $error("Latch still set after cycle end.");
  latch_needed_a: assert property ($rose(prog_reg) |->
    $past(latch_reg))
    else $error("Cycle began with latch clear.");
  chip_prot_a: assert property (eraseValid && req_reg.kind == K_CHIP
    |-> $past(protectBits) == 5'h00)
    else $error("Whole clear while protected.");
  busy_read_a: assert property (state_reg == ST_DADDR |-> !prog_reg)
    else $error("Dual read accepted while busy.");
  cont_set_a: assert property ($rose(cont_reg) |->
    $past(state_reg) == ST_DMODE &&
    mode_reg[MODE_LO+1:MODE_LO] == CONT_KEY)
    else $error("Continuous mode set without key.");
  stat_out_a: assert property (fallEdge && state_reg == ST_STAT
    |=> sioOe == 2'h2)
    else $error("Status not driven.");
  b32_prot_a: assert property ($rose(prog_reg) && !eraseValid
    |-> busyKind_reg == K_B32)
    else $error("Protected cycle for wrong kind.");
  sect_base_a: assert property (eraseValid && req_reg.kind == K_SECT
    |-> req_reg.addr[SECT_SH-1:0] == '0)
    else $error("Sector base not aligned.");
  boundary_a: assert property ($rose(prog_reg) |->
    $past(bitCnt_reg) == SER_BITS || $past(bitCnt_reg) == OPC_BITS)
    else $error("Cycle began off a byte boundary.");

  clear_run_c: cover property (eraseValid ##1 prog_reg [*3] ##1 !selS2);
  cont_mode_c: cover property ($rose(cont_reg));
  poll_busy_c: cover property (prog_reg && state_reg == ST_STAT);
  prot32_c: cover property ($rose(prog_reg) && !eraseValid);

endmodule

// ==== tb/sfe_host_model.sv ====
// Host controller model that drives the four-wire serial flash bus.
`timescale 1ns/1ps
module sfe_host_model (
  input wire logic clk,
  input wire logic [1:0] sioOut,
  input wire logic [1:0] sioOe,
  output logic selN,
  output logic sclk,
  output logic [1:0] sioIn
);
  logic [1:0] drv;
  logic drvEn;

  // Device drive wins; a released host line shows the inverse of its last
  // value, so a stale level can never pass for fresh data.
  assign sioIn = (sioOe & sioOut) | (~sioOe & (drvEn ? drv : ~drv));

  // Deselected at start, with the clock parked low as mode 0 wants.
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    drv = 2'b00;
    drvEn = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic open();
    selN = 1'b0;
    tick(4);
  endtask

  // Select stays high long enough for the device synchronisers.
  task automatic close();
    drvEn = 1'b0;
    selN = 1'b1;
    tick(8);
  endtask

  // One bus clock per bit or bit pair, MSB first, 80 ns per clock; pins are
  // sampled just before each rising edge, serial output read on lane 1.
  task automatic clocks(input logic [63:0] d, input int n, input int w,
                        input bit en, inout logic [63:0] q);
    for (int i = 0; i < n; i++) begin
      drvEn = en;
      drv = (w == 2) ? d[63-2*i -: 2] : {1'b0, d[63-i]};
      tick(4);
      q = (w == 2) ? {q[61:0], sioIn} : {q[62:0], sioIn[1]};
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
  endtask
endmodule

// ==== tb/sfe_sequencer_tb.sv ====
// Self-checking bench for the serial flash clear and dual read sequencer.
`timescale 1ns/1ps
module sfe_sequencer_tb;
  import sfe_pkg::*;
  localparam int CYC = 400;
  logic clk, srst, selN, sclk, eraseValid, writeInProgress;
  logic writeEnableLatch, contReadActive, laneSeen, latchAfter;
  logic [1:0] sioIn, sioOut, sioOe;
  logic [4:0] protectBits;
  logic [7:0] arrayData, st;
  logic [ADDR_W-1:0] arrayRdAddr;
  sfe_erase_t eraseReq, lastReq;
  int errors, comparisons, pulses, busyCnt, busyLast;
  logic [63:0] q;

  sfe_sequencer #(.PAGE_CYC(CYC), .SECT_CYC(CYC), .B32_CYC(CYC),
    .B64_CYC(CYC), .CHIP_CYC(CYC)) sfe_sequencer_i (.clk(clk), .srst(srst),
    .selN(selN), .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe),
    .protectBits(protectBits), .arrayData(arrayData),
    .arrayRdAddr(arrayRdAddr), .eraseValid(eraseValid), .eraseReq(eraseReq),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
    .contReadActive(contReadActive));
  sfe_host_model sfe_host_model_i (.clk(clk), .sioOut(sioOut),
    .sioOe(sioOe), .selN(selN), .sclk(sclk), .sioIn(sioIn));

  // Array content is a fixed pattern of the address, so reads are checkable.
  assign arrayData = arrayRdAddr[7:0] ^ 8'hA5;

  always #5 clk = ~clk;

  // Log clear requests, lane 0 drive and the length of each busy stretch.
  always @(posedge clk) begin
    if (eraseValid) begin
      pulses = pulses + 1;
      lastReq = eraseReq;
    end
    if (sioOe[0]) laneSeen = 1'b1;
    if (writeInProgress) busyCnt = busyCnt + 1;
    else if (busyCnt != 0) begin
      busyLast = busyCnt;
      latchAfter = writeEnableLatch;
      busyCnt = 0;
    end
  end

  task automatic conclude();
    $display("%0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic serial(input logic [31:0] v, input int n);
    sfe_host_model_i.open();
    sfe_host_model_i.clocks({v, 32'h0000_0000}, n, 1, 1, q);
    sfe_host_model_i.close();
  endtask

  task automatic status();
    sfe_host_model_i.open();
    sfe_host_model_i.clocks({OP_RDSR, 56'h0}, 16, 1, 1, q);
    sfe_host_model_i.close();
    st = q[7:0];
  endtask

  // A bounded wait; running out of patience counts as a mismatch.
  task automatic waitIdle();
    int n;
    n = 0;
    while (writeInProgress !== 1'b0 && n < 4000) begin
      sfe_host_model_i.tick(1);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      $display("mismatch at %0t: busy never ended", $time);
      conclude();
    end else begin
      sfe_host_model_i.tick(3);
    end
  endtask

  task automatic clear(input logic [7:0] op, input logic [23:0] a,
      input int n, input bit write_enable_cmd, input bit busy, input bit fire,
      input sfe_kind_t k, input logic [17:0] base);
    int p;
    p = pulses;
    if (write_enable_cmd) serial({OP_WR_EN, 24'h00_0000}, 8);
    serial({op, a}, n);
    status();
    check(st, busy ? 8'h03 : {6'h00, write_enable_cmd, 1'b0}, "status");
    waitIdle();
    check(pulses - p, fire, "pulses");
    if (fire) check(lastReq, {k, base}, "region");
    if (busy) check({busyLast, latchAfter}, {CYC + 1, 1'b0}, "busy");
    check(writeEnableLatch, write_enable_cmd & ~busy, "latch");
  endtask

  task automatic dread(input bit opc, input logic [23:0] a,
                       input logic [7:0] m);
    sfe_host_model_i.open();
    if (opc) sfe_host_model_i.clocks({OP_DREAD, 56'h0}, 8, 1, 1, q);
    sfe_host_model_i.clocks({a, m, 32'h0000_0000}, 16, 2, 1, q);
    sfe_host_model_i.clocks(64'h0, 8, 2, 0, q);
    sfe_host_model_i.close();
  endtask

  function automatic logic [15:0] twoBytes(input logic [23:0] a);
    return {a[7:0] ^ 8'hA5, (a[7:0] + 8'h01) ^ 8'hA5};
  endfunction

  // Main sequence: reset, clear kinds, refusals, protection, dual reads.
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    protectBits = 5'h00;
    {errors, comparisons, pulses, busyCnt, busyLast} = '0;
    {latchAfter, laneSeen, q} = '0;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    check({eraseValid, writeInProgress, writeEnableLatch, contReadActive,
      sioOe}, 6'h00, "reset");
    sfe_host_model_i.tick(3);
    clear(OP_SECT, 24'h01_2345, 32, 1, 1, 1, K_SECT, 18'h1_2000);
    clear(OP_SECT, 24'h01_2345, 32, 0, 0, 0, K_SECT, 18'h0);
    clear(OP_PAGE, 24'h01_23AB, 32, 1, 1, 1, K_PAGE, 18'h1_2300);
    clear(OP_B32, 24'h01_ABCD, 32, 1, 1, 1, K_B32, 18'h1_8000);
    clear(OP_B64, 24'h01_ABCD, 32, 1, 1, 1, K_B64, 18'h1_0000);
    clear(OP_CHIP_A, 24'h0, 8, 1, 1, 1, K_CHIP, 18'h0);
    clear(OP_CHIP_B, 24'h0, 8, 1, 1, 1, K_CHIP, 18'h0);
    $display("test clear kinds done");
    clear(OP_SECT, 24'h01_2345, 31, 1, 0, 0, K_SECT, 18'h0);
    clear(OP_B64, 24'h01_2345, 40, 1, 0, 0, K_B64, 18'h0);
    clear(OP_CHIP_B, 24'h0, 16, 1, 0, 0, K_CHIP, 18'h0);
    $display("test frame length done");
    protectBits = 5'h01;
    clear(OP_SECT, 24'h03_F800, 32, 1, 0, 0, K_SECT, 18'h0);
    clear(OP_B32, 24'h03_F800, 32, 1, 1, 0, K_B32, 18'h0);
    clear(OP_B64, 24'h03_0000, 32, 1, 0, 0, K_B64, 18'h0);
    clear(OP_CHIP_A, 24'h0, 8, 1, 0, 0, K_CHIP, 18'h0);
    clear(OP_SECT, 24'h00_0123, 32, 1, 1, 1, K_SECT, 18'h0);
    protectBits = 5'h00;
    $display("test protection done");
    dread(1, 24'h00_1234, 8'h20);
    check(q[15:0], twoBytes(24'h00_1234), "dual data");
    check(contReadActive, 1'b1, "armed");
    dread(0, 24'h00_2FFF, 8'h00);
    check(q[15:0], twoBytes(24'h00_2FFF), "no-opcode data");
    check(contReadActive, 1'b0, "disarmed");
    status();
    check(st, 8'h00, "normal decode");
    dread(1, 24'h00_0010, 8'h20);
    serial({OP_CRRST, 24'h00_0000}, 8);
    check(contReadActive, 1'b0, "reset frame");
    status();
    check(st, 8'h00, "decode after reset");
    $display("test dual read done");
    serial({OP_WR_EN, 24'h00_0000}, 8);
    serial({OP_SECT, 24'h00_5000}, 32);
    laneSeen = 1'b0;
    dread(1, 24'h00_0000, 8'h00);
    check(laneSeen, 1'b0, "drive while busy");
    waitIdle();
    check(busyLast, CYC + 1, "busy undisturbed");
    $display("test busy read done");
    conclude();
  end
endmodule
